// ===== pid_coeff_result_error_regs.sv
/*
 apb register bank of the pid accelerator holding the derivative
 coefficient, the 36-bit result and the 17-bit previous error term, plus
 a status register showing the calculation-in-progress flag.
 assumes the pid datapath runs on pclk and drives calc_* pulses.
*/
//
// Behaviour
// - 16-bit derivative coefficient, high and low byte, both read/write.
// - result loaded whenever calc_upd.result_load is high, not tied to calc_done; software reads and writes it.
// - result spread over five byte registers, top holds bits 35 to 32.
// - previous error term holds last iteration's input minus set point.
// - previous error term is 17 bits over upper, high and low registers.
// - unused bits read zero and ignore writes.
// - all implemented bits clear to zero on every reset.
// - busy flag set when calculating starts, cleared when done.
`timescale 1ns/100ps
`default_nettype none
`include "pid_regs_params.svh"

module pid_coeff_result_error_regs
   import pid_regs_pkg::*;
(
   input wire logic pclk, // bus clock, 20 mhz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [`ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data, registered
   output logic pready, // apb ready, always high
   output logic pslverr, // apb error on unmapped address
   input wire logic calc_start, // pulse: calculation begins
   input wire logic calc_done, // pulse: calculation finished
   input wire calc_upd_t calc_upd, // datapath result and error update
   output logic [`COEFF_W-1:0] deriv_coefficient, // coefficient to datapath
   output logic [`RESULT_W-1:0] result_value, // current result
   output logic [`ERROR_W-1:0] previous_error_term, // error history to datapath
   output logic busy // calculation in progress
);

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [`COEFF_W-1:0] coeff;
      logic [`RESULT_W-1:0] result;
      logic [`ERROR_W-1:0] err;
      logic [31:0] rdata;
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;
   apb_req_t req;
   reg_sel_t sel;
   logic busy_int;
   logic access;
   logic setup;
   logic wr_en;
   logic [`BYTE_W-1:0] wbyte;

   ////////////////////////////////////////////////////////////////////////
   // bus capture and decode

   // gather apb signals into one request
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                  wdata: pwdata, strb: pstrb};

   pid_addr_decode u_decode
   (
      .addr(req.addr),
      .sel(sel)
   );

   pid_busy_tracker u_busy
   (
      .pclk(pclk),
      .presetn(presetn),
      .calc_start(calc_start),
      .calc_done(calc_done),
      .busy(busy_int)
   );

   // zero-wait access, writes only through byte lane 0
   assign access = req.sel && req.enable;
   assign setup = req.sel && !req.enable;
   assign wr_en = access && req.write && req.strb[0];
   assign wbyte = req.wdata[`BYTE_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   // software writes win over a same-cycle datapath update of that byte
   always_comb
   begin
      state_next = state_reg;
      if (calc_upd.result_load)
         state_next.result = calc_upd.result_val;
      if (calc_upd.error_load)
         state_next.err = calc_upd.error_val;
      if (wr_en)
      begin
         case (sel)
            SEL_COEFF_HI: state_next.coeff[15:8] = wbyte;
            SEL_COEFF_LO: state_next.coeff[7:0] = wbyte;
            SEL_RES_TOP: state_next.result[35:32] = wbyte[3:0];
            SEL_RES_B3: state_next.result[31:24] = wbyte;
            SEL_RES_B2: state_next.result[23:16] = wbyte;
            SEL_RES_B1: state_next.result[15:8] = wbyte;
            SEL_RES_B0: state_next.result[7:0] = wbyte;
            SEL_ERR_TOP: state_next.err[16] = wbyte[0];
            SEL_ERR_HI: state_next.err[15:8] = wbyte;
            SEL_ERR_LO: state_next.err[7:0] = wbyte;
            default: state_next.coeff = state_next.coeff;
         endcase
      end
      // read data captured at the setup edge so it stands through the access
      // phase; a datapath load in that one cycle shows on the next read
      if (setup && !req.write)
      begin
         case (sel)
            SEL_COEFF_HI: state_next.rdata = {24'h000000, state_reg.coeff[15:8]};
            SEL_COEFF_LO: state_next.rdata = {24'h000000, state_reg.coeff[7:0]};
            SEL_RES_TOP: state_next.rdata = {28'h0000000, state_reg.result[35:32]};
            SEL_RES_B3: state_next.rdata = {24'h000000, state_reg.result[31:24]};
            SEL_RES_B2: state_next.rdata = {24'h000000, state_reg.result[23:16]};
            SEL_RES_B1: state_next.rdata = {24'h000000, state_reg.result[15:8]};
            SEL_RES_B0: state_next.rdata = {24'h000000, state_reg.result[7:0]};
            SEL_ERR_TOP: state_next.rdata = {31'h00000000, state_reg.err[16]};
            SEL_ERR_HI: state_next.rdata = {24'h000000, state_reg.err[15:8]};
            SEL_ERR_LO: state_next.rdata = {24'h000000, state_reg.err[7:0]};
            SEL_STATUS: state_next.rdata = 32'h00000000 | (32'h00000001 << `STATUS_BUSY_BIT)
                                           & {32{busy_int}};
            default: state_next.rdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // every implemented bit clears on reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg.coeff <= `COEFF_RST;
         state_reg.result <= `RESULT_RST;
         state_reg.err <= `ERROR_RST;
         state_reg.rdata <= 32'h00000000;
      end
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // no wait states; read data already stands during the access phase
   assign pready = 1'b1;
   assign pslverr = access && (sel == SEL_NONE);
   assign prdata = state_reg.rdata;
   assign deriv_coefficient = state_reg.coeff;
   assign result_value = state_reg.result;
   assign previous_error_term = state_reg.err;
   assign busy = busy_int;

endmodule
`default_nettype wire

// ===== pid_regs_params.svh
/*
 constants for the coefficient, result and error-history register bank:
 byte offsets, field widths and positions, reset values.
 assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PID_REGS_PARAMS_SVH
`define PID_REGS_PARAMS_SVH

// register byte addresses on the apb bus
`define OFS_DERIV_COEFF_HIGH 12'h000
`define OFS_DERIV_COEFF_LOW 12'h004
`define OFS_RESULT_TOP_NIBBLE 12'h008
`define OFS_RESULT_BYTE3 12'h00C
`define OFS_RESULT_BYTE2 12'h010
`define OFS_RESULT_BYTE1 12'h014
`define OFS_RESULT_BYTE0 12'h018
`define OFS_PREV_ERROR_TOP_BIT 12'h01C
`define OFS_PREV_ERROR_HIGH 12'h020
`define OFS_PREV_ERROR_LOW 12'h024
`define OFS_STATUS 12'h028

// field widths
`define COEFF_W 16
`define RESULT_W 36
`define ERROR_W 17
`define BYTE_W 8
`define ADDR_W 12
`define NUM_BYTE_REGS 10

// reset values
`define COEFF_RST 16'h0000
`define RESULT_RST 36'h0_0000_0000
`define ERROR_RST 17'h0_0000

// status register bit position
`define STATUS_BUSY_BIT 0

`endif

// ===== pid_regs_pkg.sv
/*
 types shared by the register bank and its helpers.
 assumes pid_regs_params.svh is on the include path.
*/
`include "pid_regs_params.svh"

package pid_regs_pkg;

   // one apb request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [`ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic [3:0] strb;
   } apb_req_t;

   // datapath update of result and error history
   typedef struct packed {
      logic result_load;
      logic [`RESULT_W-1:0] result_val;
      logic error_load;
      logic [`ERROR_W-1:0] error_val;
   } calc_upd_t;

   // byte register selectors
   typedef enum logic [3:0] {
      SEL_COEFF_HI,
      SEL_COEFF_LO,
      SEL_RES_TOP,
      SEL_RES_B3,
      SEL_RES_B2,
      SEL_RES_B1,
      SEL_RES_B0,
      SEL_ERR_TOP,
      SEL_ERR_HI,
      SEL_ERR_LO,
      SEL_STATUS,
      SEL_NONE
   } reg_sel_t;

endpackage

// ===== pid_addr_decode.sv
/*
 address decoder: maps an apb byte address to a register selector.
 assumes word-aligned addresses; anything else decodes as unmapped.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pid_regs_params.svh"

module pid_addr_decode
   import pid_regs_pkg::*;
(
   input wire logic [`ADDR_W-1:0] addr, // apb byte address
   output reg_sel_t sel // decoded register
);

   // address to selector lookup
   function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      case (a)
         `OFS_DERIV_COEFF_HIGH: s = SEL_COEFF_HI;
         `OFS_DERIV_COEFF_LOW: s = SEL_COEFF_LO;
         `OFS_RESULT_TOP_NIBBLE: s = SEL_RES_TOP;
         `OFS_RESULT_BYTE3: s = SEL_RES_B3;
         `OFS_RESULT_BYTE2: s = SEL_RES_B2;
         `OFS_RESULT_BYTE1: s = SEL_RES_B1;
         `OFS_RESULT_BYTE0: s = SEL_RES_B0;
         `OFS_PREV_ERROR_TOP_BIT: s = SEL_ERR_TOP;
         `OFS_PREV_ERROR_HIGH: s = SEL_ERR_HI;
         `OFS_PREV_ERROR_LOW: s = SEL_ERR_LO;
         `OFS_STATUS: s = SEL_STATUS;
         default: s = SEL_NONE;
      endcase
      return s;
   endfunction

   // combinational decode
   always_comb
   begin
      sel = decode(addr);
   end

endmodule
`default_nettype wire

// ===== pid_busy_tracker.sv
/*
 calculation-in-progress flag: set by a start pulse, cleared by a done
 pulse. assumes start and done come from logic on pclk.
*/
`timescale 1ns/100ps
`default_nettype none

module pid_busy_tracker
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, active low
   input wire logic calc_start, // pulse: calculation begins
   input wire logic calc_done, // pulse: calculation finished
   output logic busy // level: calculating
);

   typedef struct packed {
      logic busy;
   } busy_state_t;

   busy_state_t state_reg;
   busy_state_t state_next;

   // start wins over a coincident done so a new run is not lost
   always_comb
   begin
      state_next = state_reg;
      if (calc_start)
         state_next.busy = 1'b1;
      else if (calc_done)
         state_next.busy = 1'b0;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign busy = state_reg.busy;

endmodule
`default_nettype wire

// ===== pid_regs_sva.sv
/*
 checker for the coefficient, result and error-history register bank.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pid_regs_params.svh"

module pid_regs_sva
   import pid_regs_pkg::*;
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [`ADDR_W-1:0] paddr, // byte address
   input wire logic [31:0] pwdata, // write data
   input wire logic [3:0] pstrb, // byte strobes
   input wire logic pslverr, // apb error
   input wire logic calc_start, // start pulse
   input wire logic calc_done, // done pulse
   input wire calc_upd_t calc_upd, // datapath update
   input wire logic [`COEFF_W-1:0] deriv_coefficient, // coefficient
   input wire logic [`RESULT_W-1:0] result_value, // result
   input wire logic [`ERROR_W-1:0] previous_error_term, // error history
   input wire logic busy // calculating
);
   logic wr;

   // a write is taken at this edge
   assign wr = psel && penable && pwrite && pstrb[0];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   a_busy_set: assert property (calc_start |=> busy)
      else $error("busy not set after start");
   a_busy_clear: assert property (calc_done && !calc_start |=> !busy)
      else $error("busy not cleared after done");
   a_busy_hold: assert property (!calc_start && !calc_done |=> $stable(busy))
      else $error("busy moved without cause");
   a_coeff_hi_write: assert property (wr && paddr == `OFS_DERIV_COEFF_HIGH
      |=> deriv_coefficient[15:8] == $past(pwdata[7:0])) else $error("coefficient high lost");
   a_res_top_write: assert property (wr && paddr == `OFS_RESULT_TOP_NIBBLE
      |=> result_value[35:32] == $past(pwdata[3:0])) else $error("result top lost");
   a_err_top_write: assert property (wr && paddr == `OFS_PREV_ERROR_TOP_BIT
      |=> previous_error_term[16] == $past(pwdata[0])) else $error("error top bit lost");
   a_res_load: assert property (calc_upd.result_load && !wr
      |=> result_value == $past(calc_upd.result_val)) else $error("result not loaded");
   a_err_load: assert property (calc_upd.error_load && !wr
      |=> previous_error_term == $past(calc_upd.error_val)) else $error("error not loaded");
   a_unmapped_err: assert property (psel && penable && paddr > `OFS_STATUS |-> pslverr)
      else $error("no error on unmapped address");
endmodule

bind pid_coeff_result_error_regs pid_regs_sva u_sva (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .calc_start, .calc_done, .calc_upd,
   .deriv_coefficient, .result_value, .previous_error_term, .busy);
`default_nettype wire

// ===== pid_coeff_result_error_regs_tb_top.sv
/*
 self-checking bench for the register bank, apb master tasks included.
 assumes a zero-wait slave whose read data stands during the access phase.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pid_regs_params.svh"

module pid_coeff_result_error_regs_tb_top
   import pid_regs_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic calc_start = 1'b0;
   logic calc_done = 1'b0;
   calc_upd_t calc_upd = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic [`COEFF_W-1:0] deriv_coefficient;
   logic [`RESULT_W-1:0] result_value;
   logic [`ERROR_W-1:0] previous_error_term;
   logic [31:0] rdat;
   logic last_err = 1'b0;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] pat [10] = '{8'hA5, 8'h3C, 8'hDB, 8'h81, 8'h7E, 8'h42, 8'hC3, 8'hFF, 8'h96, 8'h69};
   logic [7:0] msk [10] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF};

   pid_coeff_result_error_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .calc_start, .calc_done, .calc_upd,
      .deriv_coefficient, .result_value, .previous_error_term, .busy);

   // 20 mhz clock
   always #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; read data and error taken at the edge ending the access
   task automatic xfer(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // counts and verdict
   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         num_errors++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         xfer(1'b0, 12'(i * 4), 32'h0, rdat);
         check(40'(rdat), 40'h0);
      end
      for (int i = 0; i < 10; i++)
         xfer(1'b1, 12'(i * 4), {24'hFFFFFF, pat[i]}, rdat);
      for (int i = 0; i < 10; i++)
      begin
         xfer(1'b0, 12'(i * 4), 32'h0, rdat);
         check(40'(rdat), 40'(pat[i] & msk[i]));
      end
      check(40'(deriv_coefficient), {24'h0, pat[0], pat[1]});
      check(40'(result_value), {4'h0, pat[2][3:0], pat[3], pat[4], pat[5], pat[6]});
      check(40'(previous_error_term), {23'h0, pat[7][0], pat[8], pat[9]});
      // unmapped place reads zero and keeps nothing
      xfer(1'b1, 12'h02C, 32'hFF, rdat);
      xfer(1'b0, 12'h02C, 32'h0, rdat);
      check(40'(rdat), 40'h0);
      check(40'(last_err), 40'h1);
      // datapath loads with a calculation running
      @(posedge pclk);
      calc_upd <= '{1'b1, 36'h9_8765_4321, 1'b1, 17'h1_2345};
      calc_start <= 1'b1;
      @(posedge pclk);
      calc_upd <= '0;
      calc_start <= 1'b0;
      xfer(1'b0, `OFS_STATUS, 32'h0, rdat);
      check(40'(rdat), 40'h1);
      check(40'(last_err), 40'h0);
      check(40'(result_value), 40'h9_8765_4321);
      check(40'(previous_error_term), 40'h1_2345);
      calc_done <= 1'b1;
      @(posedge pclk);
      calc_done <= 1'b0;
      @(posedge pclk);
      check(40'(busy), 40'h0);
      // reset after the run clears the coefficient, result and error term
      presetn <= 1'b0;
      @(posedge pclk);
      check(40'(result_value), 40'h0);
      check(40'(deriv_coefficient), 40'h0);
      check(40'(previous_error_term), 40'h0);
      // bank works again once reset is released
      presetn <= 1'b1;
      xfer(1'b1, `OFS_DERIV_COEFF_LOW, 32'h5A, rdat);
      xfer(1'b0, `OFS_DERIV_COEFF_LOW, 32'h0, rdat);
      check(40'(rdat), 40'h5A);
      xfer(1'b0, `OFS_RESULT_BYTE0, 32'h0, rdat);
      check(40'(rdat), 40'h0);
      finish_test();
   end
endmodule
`default_nettype wire
